// ==== eight_bit_interval_timer_counter_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, b) \
  comparisons++; \
  if ((a) !== (b)) begin \
    err_total++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); \
  end
module eight_bit_interval_timer_counter_tb_top;
  import tc_pkg::*;
  logic i_ref_clk, i_rst_n, i_wr_byte, i_wr_bit, i_bit_val, i_rd;
  logic [ADDR_W-1:0] i_addr;
  logic [7:0] i_wdata, o_rdata, r, r2;
  logic [1:0] i_bit_pos;
  logic i_event_clock_pin, i_match_interrupt_enable, i_request_clear;
  logic o_match_request_flag, o_match_irq, o_irq_service;
  logic o_clock_output_pin, o_clock_output_en;
  int err_total, comparisons, n;

  interval_timer DUT (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wr_byte(i_wr_byte), .i_wdata(i_wdata),
    .i_wr_bit(i_wr_bit), .i_bit_pos(i_bit_pos), .i_bit_val(i_bit_val),
    .i_rd(i_rd), .i_event_clock_pin(i_event_clock_pin),
    .i_match_interrupt_enable(i_match_interrupt_enable),
    .i_request_clear(i_request_clear), .o_rdata(o_rdata),
    .o_match_request_flag(o_match_request_flag),
    .o_match_irq(o_match_irq), .o_irq_service(o_irq_service),
    .o_clock_output_pin(o_clock_output_pin),
    .o_clock_output_en(o_clock_output_en));

  event_source_model src (.i_ref_clk(i_ref_clk),
    .o_event_clock_pin(i_event_clock_pin));

  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  task automatic tick;
    @(posedge i_ref_clk);
    #2;
  endtask : tick

  task automatic wr_byte(input logic [11:0] a, input logic [7:0] d);
    i_addr = a;
    i_wdata = d;
    i_wr_byte = 1'b1;
    tick;
    i_wr_byte = 1'b0;
    // one idle edge, so a next call never re-raises the strobe at once
    tick;
  endtask : wr_byte

  task automatic wr_bit(input logic [11:0] a, input logic [1:0] p,
                        input logic v);
    i_addr = a;
    i_bit_pos = p;
    i_bit_val = v;
    i_wr_bit = 1'b1;
    tick;
    i_wr_bit = 1'b0;
    tick;
  endtask : wr_bit

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    i_addr = a;
    i_rd = 1'b1;
    tick;
    i_rd = 1'b0;
    d = o_rdata;
    tick;
  endtask : rd

  // bounded wait; c counts cycles spent waiting
  task automatic wait_irq(output int c);
    c = 0;
    while (o_match_irq !== 1'b1 && c < 3000) begin
      tick;
      c++;
    end
    `CHK(c < 3000, 1'b1)
  endtask : wait_irq

  task automatic interval(output int c);
    wait_irq(c);
    tick;
    wait_irq(c);
    c = c + 1;
  endtask : interval

  task automatic finish_test;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_state;
    rd(ADDR_COUNT_LO, r);
    `CHK(r, COUNT_RST)
    rd(ADDR_OE, r);
    `CHK(r, 8'h00)
    rd(ADDR_LATCH, r);
    `CHK(r, 8'h00)
    rd(ADDR_MODE_LO, r);
    `CHK(r, 8'h00)
    repeat (3) tick;
    rd(ADDR_COUNT_LO, r);
    `CHK(r, 8'h00)
    `CHK(o_clock_output_en, 1'b0)
  endtask : t_reset_state

  task automatic t_intervals;
    wr_byte(ADDR_MODE_LO, 8'h7c);
    interval(n);
    `CHK(n, 256)
    wr_byte(ADDR_REF_LO, 8'h02);
    // stray bits 7, 1 and 0 set as well; they must change nothing
    wr_byte(ADDR_MODE_LO, 8'hff);
    interval(n);
    `CHK(n, 3)
    interval(n);
    `CHK(n, 3)
    `CHK(o_match_request_flag, 1'b1)
  endtask : t_intervals

  task automatic t_stop_and_pin;
    wr_byte(ADDR_REF_LO, 8'h20);
    wr_byte(ADDR_MODE_LO, 8'h7c);
    wait_irq(n);
    wr_byte(ADDR_MODE_LO, 8'h70);
    rd(ADDR_LATCH, r);
    `CHK(r, 8'h02)
    rd(ADDR_COUNT_LO, r);
    repeat (4) tick;
    rd(ADDR_COUNT_LO, r2);
    `CHK(r2, r)
    rd(ADDR_LATCH, r);
    `CHK(r, 8'h02)
    i_match_interrupt_enable = 1'b0;
    tick;
    `CHK(o_irq_service, 1'b0)
    i_match_interrupt_enable = 1'b1;
    tick;
    `CHK(o_irq_service, 1'b1)
    i_request_clear = 1'b1;
    tick;
    i_request_clear = 1'b0;
    `CHK(o_match_request_flag, 1'b0)
    wr_bit(ADDR_OE, OE_POS, 1'b1);
    rd(ADDR_OE, r);
    `CHK(r, 8'h04)
    tick;
    `CHK(o_clock_output_en, 1'b1)
    `CHK(o_clock_output_pin, 1'b1)
    wr_bit(ADDR_OE, OE_POS, 1'b0);
    tick;
    `CHK(o_clock_output_pin, 1'b0)
    wr_bit(ADDR_MODE_LO, MODE_RESTART_POS, 1'b1);
    rd(ADDR_LATCH, r);
    `CHK(r, 8'h00)
    rd(ADDR_COUNT_LO, r);
    `CHK(r, 8'h00)
  endtask : t_stop_and_pin

  task automatic t_restart_running;
    wr_byte(ADDR_MODE_LO, 8'h7c);
    wait_irq(n);
    `CHK(o_match_request_flag, 1'b1)
    // the /1 source pulses on the very edge that takes the restart
    wr_byte(ADDR_MODE_LO, 8'h7c);
    `CHK(o_match_request_flag, 1'b0)
    // one /1 pulse after the restart edge: 1 if restart won, 2 if not
    rd(ADDR_COUNT_LO, r);
    `CHK(r, 8'h01)
    rd(ADDR_LATCH, r);
    `CHK(r, 8'h00)
    repeat (5) tick;
    rd(ADDR_COUNT_LO, r);
    `CHK(r, 8'h0a)
  endtask : t_restart_running

  task automatic t_event_pin;
    wr_byte(ADDR_REF_LO, 8'hff);
    wr_byte(ADDR_MODE_LO, {1'b0, SRC_EXT_RISE, 4'hc});
    src.pulses(4);
    src.hold(1'b1);
    repeat (6) tick;
    rd(ADDR_COUNT_LO, r);
    `CHK(r, 8'h05)
    // pin starts high here, so the first fall comes 3 cycles in
    wr_byte(ADDR_MODE_LO, {1'b0, SRC_EXT_FALL, 4'hc});
    src.pulses(4);
    repeat (6) tick;
    rd(ADDR_COUNT_LO, r);
    `CHK(r, 8'h04)
  endtask : t_event_pin

  task automatic t_prescaler;
    logic [2:0] srcs [3];
    int divs [3];
    srcs = '{SRC_DIV16, SRC_DIV64, SRC_DIV1024};
    divs = '{16, 64, 1024};
    for (int i = 0; i < 3; i++) begin
      wr_byte(ADDR_MODE_LO, {1'b0, srcs[i], 4'hc});
      repeat (4 * divs[i] - 2) tick;
      rd(ADDR_COUNT_LO, r);
      `CHK(r >= 8'd3 && r <= 8'd4, 1'b1)
    end
    // codes 010 and 011 select no source, so the count stays at zero
    wr_byte(ADDR_MODE_LO, {1'b0, 3'h2, 4'hc});
    repeat (20) tick;
    rd(ADDR_COUNT_LO, r);
    `CHK(r, 8'h00)
  endtask : t_prescaler

  initial begin
    err_total = 0;
    comparisons = 0;
    i_rst_n = 1'b0;
    i_addr = '0;
    i_wdata = 8'h00;
    i_wr_byte = 1'b0;
    i_wr_bit = 1'b0;
    i_bit_pos = 2'h0;
    i_bit_val = 1'b0;
    i_rd = 1'b0;
    i_match_interrupt_enable = 1'b0;
    i_request_clear = 1'b0;
    repeat (6) @(posedge i_ref_clk);
    #2;
    i_rst_n = 1'b1;
    t_reset_state;
    t_intervals;
    t_stop_and_pin;
    t_restart_running;
    t_event_pin;
    t_prescaler;
    finish_test;
  end

  // the whole sequence needs well under 10000 cycles
  initial begin
    repeat (40000) @(posedge i_ref_clk);
    err_total++;
    finish_test;
  end
endmodule : eight_bit_interval_timer_counter_tb_top

// ==== event_source_model.sv ====
`timescale 1ns/1ps
module event_source_model (
  input wire logic i_ref_clk,
  output logic o_event_clock_pin
);
  // idle low between bursts, like a released source with a pull-down
  initial begin
    o_event_clock_pin = 1'b0;
  end

  // ---------------------------------------------------------------
  // edge generation
  // ---------------------------------------------------------------
  // each level lasts 3 cycles: the two sync stages need at least two
  task automatic hold(input logic lvl);
    o_event_clock_pin = lvl;
    repeat (3) @(posedge i_ref_clk);
    #2;
  endtask : hold

  task automatic pulses(input int n);
    repeat (n) begin
      hold(1'b1);
      hold(1'b0);
    end
  endtask : pulses
endmodule : event_source_model

// ==== interval_timer.sv ====
`timescale 1ns/1ps
module interval_timer
  import tc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_wr_byte,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr_bit,
  input wire logic [1:0] i_bit_pos,
  input wire logic i_bit_val,
  input wire logic i_rd,
  input wire logic i_event_clock_pin,
  input wire logic i_match_interrupt_enable,
  input wire logic i_request_clear,
  output logic [7:0] o_rdata,
  output logic o_match_request_flag,
  output logic o_match_irq,
  output logic o_irq_service,
  output logic o_clock_output_pin,
  output logic o_clock_output_en
);
  tc_tick_if tick ();

  logic [7:0] mode_r;
  logic [7:0] count_r;
  logic [7:0] ref_r;
  logic oe_r;
  logic latch_r;
  logic flag_r;
  logic irq_r;
  logic pin_r;
  logic pin_en_r;
  logic [7:0] rdata_r;
  logic restart_r;

  logic wr_mode;
  logic wr_ref;
  logic wr_oe;
  logic restart;
  logic run;
  logic pulse;
  logic match;
  logic [2:0] src;

  // ---------------------------------------------------------------
  // count sources
  // ---------------------------------------------------------------
  tc_edge_sync u_edge (
    .i_ref_clk (i_ref_clk),
    .i_rst_n (i_rst_n),
    .i_event_clock_pin (i_event_clock_pin),
    .tick (tick.ext_src)
  );

  tc_prescaler #(
    .DIV_W (DIV1024_BITS)
  ) u_presc (
    .i_ref_clk (i_ref_clk),
    .i_rst_n (i_rst_n),
    .tick (tick.div_src)
  );

  // ---------------------------------------------------------------
  // register access decode
  // ---------------------------------------------------------------
  assign wr_mode = i_wr_byte && (i_addr == ADDR_MODE_LO); // RULE_01
  assign wr_ref = i_wr_byte && (i_addr == ADDR_REF_LO); // RULE_11
  assign wr_oe = i_wr_bit && (i_addr == ADDR_OE)
                 && (i_bit_pos == OE_POS); // RULE_13
  // restart comes from a byte write or a single-bit write of bit 3
  assign restart = (wr_mode && i_wdata[MODE_RESTART])
                   || (i_wr_bit && (i_addr == ADDR_MODE_LO)
                       && (i_bit_pos == MODE_RESTART_POS)
                       && i_bit_val); // RULE_01
  assign run = mode_r[MODE_RUN];
  assign src = mode_r[MODE_SRC_LSB+2:MODE_SRC_LSB];

  // ---------------------------------------------------------------
  // mode register
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      mode_r <= MODE_RST; // RULE_02
    end else if (wr_mode) begin
      // restart and fixed-zero bits are never stored
      mode_r <= i_wdata & MODE_WMASK; // RULE_07
    end
  end

  // the restart bit lives for one cycle only, then reads back as zero
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      restart_r <= 1'b0;
    end else begin
      restart_r <= restart; // RULE_03
    end
  end

  // ---------------------------------------------------------------
  // reference and output enable
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ref_r <= REF_RST; // RULE_11
    end else if (wr_ref) begin
      ref_r <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      oe_r <= 1'b0; // RULE_15
    end else if (wr_oe) begin
      oe_r <= i_bit_val; // RULE_13
    end
  end

  // ---------------------------------------------------------------
  // count pulse select; unused source codes never count
  // ---------------------------------------------------------------
  always_comb begin
    unique case (src)
      SRC_EXT_RISE: pulse = tick.ext_rise; // RULE_05
      SRC_EXT_FALL: pulse = tick.ext_fall; // RULE_05
      SRC_DIV1024: pulse = tick.div1024; // RULE_06
      SRC_DIV64: pulse = tick.div64; // RULE_06
      SRC_DIV16: pulse = tick.div16; // RULE_06
      SRC_DIV1: pulse = 1'b1; // RULE_06
      default: pulse = 1'b0;
    endcase
  end

  // counter sits at the reference for one whole pulse period before
  // wrapping, so the interval is reference plus one pulses
  assign match = run && pulse && !restart
                 && (count_r == ref_r); // RULE_10 RULE_12

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      count_r <= COUNT_RST; // RULE_08
    end else if (restart) begin
      count_r <= COUNT_RST; // RULE_03 RULE_22
    end else if (match) begin
      count_r <= COUNT_RST; // RULE_18
    end else if (run && pulse) begin
      count_r <= count_r + 8'h01; // RULE_09
    end
  end // RULE_04

  // ---------------------------------------------------------------
  // match flag, latch, request
  // ---------------------------------------------------------------
  // a match in the same cycle as an outside clear keeps the flag set
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      flag_r <= 1'b0;
    end else if (restart) begin
      flag_r <= 1'b0; // RULE_03
    end else if (match) begin
      flag_r <= 1'b1; // RULE_10
    end else if (i_request_clear) begin
      flag_r <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      latch_r <= 1'b0;
    end else if (restart) begin
      latch_r <= 1'b0; // RULE_03
    end else if (match) begin
      latch_r <= ~latch_r; // RULE_16
    end
  end // RULE_17

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= match; // RULE_10
    end
  end

  // ---------------------------------------------------------------
  // clock output pin; port setup is left to software
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      pin_r <= 1'b0;
      pin_en_r <= 1'b0;
    end else begin
      pin_r <= oe_r & latch_r; // RULE_14
      pin_en_r <= oe_r; // RULE_14
    end
  end

  // ---------------------------------------------------------------
  // read port, one cycle latency; mode and reference read as zero
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rdata_r <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        ADDR_OE: rdata_r <= {5'h00, oe_r, 2'h0}; // RULE_13
        ADDR_LATCH: rdata_r <= {6'h00, latch_r, 1'b0}; // RULE_17
        ADDR_COUNT_LO: rdata_r <= count_r; // RULE_08
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  assign o_rdata = rdata_r;
  assign o_match_request_flag = flag_r;
  assign o_match_irq = irq_r;
  assign o_irq_service = flag_r & i_match_interrupt_enable; // RULE_19
  assign o_clock_output_pin = pin_r;
  assign o_clock_output_en = pin_en_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  reset_values_a: assert property ( // RULE_02
    @(posedge i_ref_clk) !i_rst_n |=> (mode_r == MODE_RST)
      && !oe_r && (ref_r == REF_RST) && (count_r == COUNT_RST))
    else $error("reset values wrong");

  restart_clear_a: assert property ( // RULE_03
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    restart_r |-> (count_r == COUNT_RST) && !flag_r && !latch_r
      && !mode_r[MODE_RESTART])
    else $error("restart did not clear state");

  stop_hold_a: assert property ( // RULE_04
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!run && !restart) |=> $stable(count_r))
    else $error("count moved while stopped");

  fixed_zero_a: assert property ( // RULE_07
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (mode_r & ~MODE_WMASK) == 8'h00)
    else $error("fixed mode bit not zero");

  count_step_a: assert property ( // RULE_09
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (run && pulse && !restart && (count_r != ref_r))
      |=> count_r == $past(count_r) + 8'h01)
    else $error("count did not step by one");

  match_flag_a: assert property ( // RULE_10
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    match |=> flag_r && o_match_irq)
    else $error("match did not raise request");

  fast_interval_a: assert property ( // RULE_12
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (match && (ref_r == 8'h02) && (src == SRC_DIV1)
      && !wr_mode && !wr_ref)
      ##1 (!restart && !wr_mode && !wr_ref)[*2]
      |-> (!match && !$past(match)) ##1 (match || restart))
    else $error("interval not reference plus one");

  wrap_zero_a: assert property ( // RULE_18
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    match |=> count_r == COUNT_RST)
    else $error("count did not wrap at match");

  latch_flip_a: assert property ( // RULE_16
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    match |=> latch_r != $past(latch_r))
    else $error("latch did not toggle");

  latch_hold_a: assert property ( // RULE_17
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!run && !restart) |=> $stable(latch_r))
    else $error("latch moved while stopped");

  pin_gate_a: assert property ( // RULE_14
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !oe_r |=> !o_clock_output_pin && !o_clock_output_en)
    else $error("pin driven while disabled");

  irq_gate_a: assert property ( // RULE_19
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    o_irq_service |-> i_match_interrupt_enable && flag_r)
    else $error("request forwarded while masked");

  restart_wins_a: assert property ( // RULE_22
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (restart && run && pulse) |=> count_r == COUNT_RST)
    else $error("pulse beat restart");

  edge_once_a: assert property ( // RULE_21
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    tick.ext_rise |=> !tick.ext_rise && !tick.ext_fall)
    else $error("edge pulse longer than a cycle");
endmodule : interval_timer

// ==== tc_edge_sync.sv ====
`timescale 1ns/1ps
module tc_edge_sync
  import tc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_event_clock_pin,
  tc_tick_if.ext_src tick
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic rise_r;
  logic fall_r;

  // ---------------------------------------------------------------
  // two-stage synchroniser, then edge detect on the second stage
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= i_event_clock_pin; // RULE_21
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      rise_r <= sync_r & ~prev_r; // RULE_21
      fall_r <= ~sync_r & prev_r;
    end
  end

  assign tick.ext_rise = rise_r;
  assign tick.ext_fall = fall_r;
endmodule : tc_edge_sync

// ==== tc_pkg.sv ====
// Contract
// [RULE_01] mode register, two nibbles, byte writes, restart bit-writable
// [RULE_02] reset clears mode, timer stays disabled
// [RULE_03] restart clears count, flag, latch; self-clears
// [RULE_04] run bit low holds count value
// [RULE_05] source 000 rising, 001 falling pin edges
// [RULE_06] source 100..111: clock /1024, /64, /16, /1
// [RULE_07] mode bits 7, 1, 0 always zero
// [RULE_08] count is read-only, reset to zero
// [RULE_09] increment once per selected pulse while running
// [RULE_10] equality sets match flag, raises request
// [RULE_11] reference write-only, reset to all ones
// [RULE_12] interval is reference plus one pulses
// [RULE_13] output enable flag at bit 2, bit access
// [RULE_14] latch reaches pin only while enabled
// [RULE_15] reset clears output enable flag
// [RULE_16] every match inverts output latch
// [RULE_17] disabled timer keeps latch, readable
// [RULE_18] after match count restarts from zero
// [RULE_19] request forwarded only with interrupt enable
// [RULE_20] software prepares shared port pin first
// [RULE_21] event pin double-synchronised, one-cycle edge pulses
// [RULE_22] restart beats a same-cycle count pulse
package tc_pkg;
  // ---------------------------------------------------------------
  // nibble addresses
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_MODE_LO = 12'hf90;
  localparam logic [11:0] ADDR_OE = 12'hf92;
  localparam logic [11:0] ADDR_LATCH = 12'hf93;
  localparam logic [11:0] ADDR_COUNT_LO = 12'hf94;
  localparam logic [11:0] ADDR_REF_LO = 12'hf96;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MODE_RESTART = 3;
  localparam int MODE_RUN = 2;
  localparam int MODE_SRC_LSB = 4;
  localparam logic [1:0] MODE_RESTART_POS = 2'h3;
  localparam logic [1:0] OE_POS = 2'h2;
  localparam int LATCH_POS = 1;
  localparam logic [7:0] MODE_WMASK = 8'h74;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] REF_RST = 8'hff;
  // ---------------------------------------------------------------
  // count sources
  // ---------------------------------------------------------------
  localparam logic [2:0] SRC_EXT_RISE = 3'h0;
  localparam logic [2:0] SRC_EXT_FALL = 3'h1;
  localparam logic [2:0] SRC_DIV1024 = 3'h4;
  localparam logic [2:0] SRC_DIV64 = 3'h5;
  localparam logic [2:0] SRC_DIV16 = 3'h6;
  localparam logic [2:0] SRC_DIV1 = 3'h7;
  localparam int DIV1024_BITS = 10;
  localparam int DIV64_BITS = 6;
  localparam int DIV16_BITS = 4;
endpackage : tc_pkg

// ==== tc_prescaler.sv ====
`timescale 1ns/1ps
module tc_prescaler
  import tc_pkg::*;
#(
  parameter int DIV_W = DIV1024_BITS
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  tc_tick_if.div_src tick
);
  logic [DIV_W-1:0] div_r;
  logic t1024_r;
  logic t64_r;
  logic t16_r;

  generate
    if (DIV_W < DIV1024_BITS) begin : g_bad_width
      $error("prescaler narrower than the /1024 tap");
    end
  endgenerate

  // ---------------------------------------------------------------
  // free-running divider; taps fire once per wrap of their low bits
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      t1024_r <= 1'b0;
      t64_r <= 1'b0;
      t16_r <= 1'b0;
    end else begin
      t1024_r <= &div_r[DIV1024_BITS-1:0]; // RULE_06
      t64_r <= &div_r[DIV64_BITS-1:0];
      t16_r <= &div_r[DIV16_BITS-1:0];
    end
  end

  assign tick.div1024 = t1024_r;
  assign tick.div64 = t64_r;
  assign tick.div16 = t16_r;
endmodule : tc_prescaler

// ==== tc_tick_if.sv ====
`timescale 1ns/1ps
interface tc_tick_if;
  logic ext_rise;
  logic ext_fall;
  logic div1024;
  logic div64;
  logic div16;
  modport ext_src (output ext_rise, output ext_fall);
  modport div_src (output div1024, output div64, output div16);
  modport sink (input ext_rise, input ext_fall, input div1024,
                input div64, input div16);
endinterface : tc_tick_if
